// *** hdl/pfm_pin_mux.sv ***
// pfm_pin_mux: port pin alternate functions, level/nmi/abort requests, bus status pin
// assumes: all pins synchronous to sys_clk_in; register bits arrive as plain ports
//
// Operation
// - each chip select reaches its port 7 pin only when its enable bit is set
// - level interrupt input held low sets edge flag bit seven
// - level interrupt reaches cpu only with enable bit seven set and i flag clear
// - level request is not latched; it lasts while the input stays low
// - nmi enable bit set: every falling edge on nmi pin requests interrupt
// - i flag never blocks the nonmaskable request
// - abort enable bit set enables the abort function on the shared pin
// - serial receive enable turns the even port 6 pin into receive input
// - serial transmit enable turns the odd port 6 pin into transmit output
// - timer 4 counts negative input pulses when serial receive 0 is disabled
// - timer output pin toggles on every timer 4 time-out
// - timer 4 input shares pin P60 and its output pin P61
// - bus-available in phase-two low is high for internal bus use, low for external use
// - data-output-disable goes low in phase-two high during external writes
// - emulation: shared pin gives disable in phase-two high, bus-available in low
// - normal mode: bus-available in phase-two low, constant one in high
// - polarity bit clear: host selects with active-low chip select and write enable
// - polarity bit set: host select is the active-high chip select
// - host interrupt leaves on its own dedicated output
// - chosen pwm edges copy timer 7 counter to latch and set edge flag three
`timescale 1ns/1ps
`default_nettype none
module pfm_pin_mux #(
  parameter int unsigned NUM_CS = pfm_pkg::num_cs,
  parameter int unsigned NUM_UART = pfm_pkg::num_uart,
  parameter int unsigned TIMER_WIDTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // chip select port
  input wire logic [NUM_CS-1:0] chip_select_n_in,
  input wire logic [NUM_CS-1:0] chip_select_enable_reg_in,
  input wire logic [NUM_CS-1:0] port7_data_in,
  output logic [NUM_CS-1:0] chip_select_out_n,
  // interrupts
  input wire logic level_irq_in_n,
  input wire logic edge_enable_bit_seven_in,
  input wire logic cpu_irq_disable_in,
  input wire logic edge_flag_clear_in,
  output logic edge_flag_bit_seven_out,
  output logic level_irq_req_out,
  input wire logic nonmaskable_irq_in_n,
  input wire pfm_pkg::pfm_bus_ctrl_type bus_ctrl_in,
  output logic nmi_req_out,
  output logic abort_req_out,
  // serial takeover of port 6
  input wire logic [NUM_UART-1:0] serial_rx_enable_in,
  input wire logic [NUM_UART-1:0] serial_tx_enable_in,
  input wire logic [NUM_UART-1:0] serial_txd_in,
  input wire logic [2*NUM_UART-1:0] port6_pin_in,
  input wire logic [2*NUM_UART-1:0] port6_data_in,
  input wire logic [2*NUM_UART-1:0] port6_dir_in,
  output logic [NUM_UART-1:0] serial_rxd_out,
  output logic [2*NUM_UART-1:0] port6_pin_out,
  output logic [2*NUM_UART-1:0] port6_pin_oe_out,
  // timer 4 pins
  input wire logic timer4_enable_in,
  input wire logic timer4_timeout_in,
  output logic timer4_count_out,
  output logic timer4_wave_out,
  // bus status pin
  input wire logic cpu_external_bus_in,
  input wire logic cpu_external_write_in,
  output logic phase_two_clock_out,
  output logic bus_avail_out,
  output logic data_out_disable_n,
  // host parallel port
  input wire logic host_port_select_polarity_in,
  input wire logic host_port_select_pin_in,
  input wire logic host_port_write_en_n,
  input wire logic [2:0] host_port_reg_select_in,
  input wire logic host_irq_event_in,
  output logic host_port_access_out,
  output logic host_port_write_out,
  output logic [2:0] host_port_reg_out,
  output logic host_port_irq_out,
  // pulse width capture
  input wire logic capture_pin_in,
  input wire logic capture_edge_sel_lo,
  input wire logic capture_edge_sel_hi,
  input wire logic [TIMER_WIDTH-1:0] timer7_count_in,
  input wire logic edge_flag_three_clear_in,
  output logic [TIMER_WIDTH-1:0] timer7_latch_out,
  output logic edge_flag_bit_three_out
);
  // ----------------------------------------
  // clocks and edge detectors
  // ----------------------------------------
  logic phase_two;
  logic nmi_fall;
  logic abort_fall;
  logic tin_fall;
  logic cap_fall;
  logic cap_rise;
  pfm_pkg::pfm_cap_mode_type cap_mode;

  pfm_phase_gen u_phase (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .phase_two_clock_out(phase_two),
    .phase_rise_out()
  );

  pfm_edge_det u_nmi_edge (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .pin_in(nonmaskable_irq_in_n),
    .fall_out(nmi_fall),
    .rise_out()
  );

  pfm_edge_det u_tin_edge (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .pin_in(port6_pin_in[0]),
    .fall_out(tin_fall),
    .rise_out()
  );

  pfm_edge_det u_cap_edge (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .pin_in(capture_pin_in),
    .fall_out(cap_fall),
    .rise_out(cap_rise)
  );

  assign abort_fall = nmi_fall;
  assign cap_mode = pfm_pkg::pfm_cap_mode_type'({capture_edge_sel_hi, capture_edge_sel_lo});

  // ----------------------------------------
  // chip selects on port 7
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      chip_select_out_n <= pfm_pkg::port7_data_reset;
    end else begin
      for (int i = 0; i < NUM_CS; i++) begin
        chip_select_out_n[i] <= chip_select_enable_reg_in[i] ? chip_select_n_in[i]
                                                               : port7_data_in[i];
      end
    end
  end

  // ----------------------------------------
  // level, nonmaskable and abort requests
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      edge_flag_bit_seven_out <= 1'b0;
      level_irq_req_out <= 1'b0;
    end else begin
      // set wins over clear
      if (!level_irq_in_n) begin
        edge_flag_bit_seven_out <= 1'b1;
      end else if (edge_flag_clear_in) begin
        edge_flag_bit_seven_out <= 1'b0;
      end
      level_irq_req_out <= ~level_irq_in_n & edge_enable_bit_seven_in
                           & ~cpu_irq_disable_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      nmi_req_out <= 1'b0;
      abort_req_out <= 1'b0;
    end else begin
      nmi_req_out <= nmi_fall & bus_ctrl_in.nmi_enable;
      abort_req_out <= abort_fall & bus_ctrl_in.abort_enable;
    end
  end

  // ----------------------------------------
  // serial and timer 4 takeover of port 6
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      serial_rxd_out <= '1;
      port6_pin_out <= '0;
      port6_pin_oe_out <= '0;
    end else begin
      for (int u = 0; u < NUM_UART; u++) begin
        serial_rxd_out[u] <= serial_rx_enable_in[u] ? port6_pin_in[2*u] : 1'b1;
        port6_pin_out[2*u] <= port6_data_in[2*u];
        port6_pin_oe_out[2*u] <= port6_dir_in[2*u] & ~serial_rx_enable_in[u];
        if (serial_tx_enable_in[u]) begin
          port6_pin_out[2*u+1] <= serial_txd_in[u];
          port6_pin_oe_out[2*u+1] <= 1'b1;
        end else if (u == 0 && timer4_enable_in) begin
          port6_pin_out[1] <= timer4_wave_out;
          port6_pin_oe_out[1] <= 1'b1;
        end else begin
          port6_pin_out[2*u+1] <= port6_data_in[2*u+1];
          port6_pin_oe_out[2*u+1] <= port6_dir_in[2*u+1];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      timer4_count_out <= 1'b0;
      timer4_wave_out <= 1'b0;
    end else begin
      // input rate assumed below half phase-two
      timer4_count_out <= tin_fall & timer4_enable_in & ~serial_rx_enable_in[0];
      if (timer4_timeout_in) begin
        timer4_wave_out <= ~timer4_wave_out;
      end
    end
  end

  // ----------------------------------------
  // bus available and data output disable
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      phase_two_clock_out <= 1'b0;
      bus_avail_out <= 1'b1;
      data_out_disable_n <= 1'b1;
    end else begin
      phase_two_clock_out <= phase_two;
      if (!phase_two) begin
        bus_avail_out <= ~cpu_external_bus_in;
      end else if (bus_ctrl_in.emulation) begin
        bus_avail_out <= ~cpu_external_write_in;
      end else begin
        bus_avail_out <= 1'b1;
      end
      data_out_disable_n <= ~(phase_two & cpu_external_write_in);
    end
  end

  // ----------------------------------------
  // host parallel port select and interrupt
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      host_port_access_out <= 1'b0;
      host_port_write_out <= 1'b0;
      host_port_reg_out <= 3'h0;
      host_port_irq_out <= 1'b0;
    end else begin
      host_port_access_out <= host_port_select_polarity_in ? host_port_select_pin_in
                                                           : ~host_port_select_pin_in;
      host_port_write_out <= ~host_port_write_en_n;
      host_port_reg_out <= host_port_reg_select_in;
      host_port_irq_out <= host_irq_event_in;
    end
  end

  // ----------------------------------------
  // pulse width capture
  // ----------------------------------------
  logic cap_hit;
  always_comb begin
    case (cap_mode)
      pfm_pkg::pfm_cap_off: cap_hit = 1'b0;
      pfm_pkg::pfm_cap_fall: cap_hit = cap_fall;
      pfm_pkg::pfm_cap_rise: cap_hit = cap_rise;
      pfm_pkg::pfm_cap_both: cap_hit = cap_fall | cap_rise;
      default: cap_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      timer7_latch_out <= '0;
      edge_flag_bit_three_out <= 1'b0;
    end else begin
      if (cap_hit) begin
        timer7_latch_out <= timer7_count_in;
        edge_flag_bit_three_out <= 1'b1;
      end else if (edge_flag_three_clear_in) begin
        edge_flag_bit_three_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_cs_mux;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    chip_select_enable_reg_in[0] |=> chip_select_out_n[0] == $past(chip_select_n_in[0]);
  endproperty
  a_cs_mux: assert property (p_cs_mux) else $error("cs0 not routed");

  property p_level_flag;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    !level_irq_in_n |=> edge_flag_bit_seven_out;
  endproperty
  a_level_flag: assert property (p_level_flag) else $error("flag seven not set");

  property p_level_req;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    level_irq_req_out |-> $past(edge_enable_bit_seven_in) && !$past(cpu_irq_disable_in);
  endproperty
  a_level_req: assert property (p_level_req) else $error("level req while masked");

  property p_level_hold;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    level_irq_req_out && $past(level_irq_in_n) |-> 1'b0;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level req latched");

  property p_nmi;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    $fell(nonmaskable_irq_in_n) && bus_ctrl_in.nmi_enable |=> nmi_req_out;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi edge missed");

  property p_abort;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    abort_req_out |-> $past(bus_ctrl_in.abort_enable);
  endproperty
  a_abort: assert property (p_abort) else $error("abort while disabled");

  property p_timer4_wave_out;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    timer4_timeout_in |=> timer4_wave_out != $past(timer4_wave_out);
  endproperty
  a_timer4_wave_out: assert property (p_timer4_wave_out) else $error("timer output did not toggle");

  property p_ba_normal;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    phase_two && !bus_ctrl_in.emulation |=> bus_avail_out;
  endproperty
  a_ba_normal: assert property (p_ba_normal) else $error("ba not high in phase high");

  property p_dod;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    !data_out_disable_n |-> $past(phase_two) && $past(cpu_external_write_in);
  endproperty
  a_dod: assert property (p_dod) else $error("disable low outside write");

  property p_cap;
    @(posedge sys_clk_in) disable iff (!resetn_in)
    cap_hit |=> edge_flag_bit_three_out && timer7_latch_out == $past(timer7_count_in);
  endproperty
  a_cap: assert property (p_cap) else $error("capture missed");
endmodule : pfm_pin_mux
`default_nettype wire

// *** hdl/pfm_pkg.sv ***
// pfm_pkg: shared constants and carrier types for the pin function mux
// assumes: single 20 MHz clock, synchronous active-low reset
package pfm_pkg;
  // ----------------------------------------
  // sizes and field positions
  // ----------------------------------------
  localparam int unsigned num_cs = 8;
  localparam int unsigned num_uart = 4;
  localparam int unsigned edge_flag_level_bit = 7;
  localparam int unsigned edge_flag_capture_bit = 3;
  localparam int unsigned bus_ctrl_emulation_pos = 3;
  localparam int unsigned bus_ctrl_abort_pos = 5;
  localparam int unsigned bus_ctrl_nmi_pos = 6;
  localparam int unsigned serial_rx_enable_pos = 0;
  localparam int unsigned serial_tx_enable_pos = 4;
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [7:0] port7_data_reset = 8'hff;
  localparam logic [7:0] cs_enable_reset = 8'h00;
  localparam logic [7:0] edge_flag_reset = 8'h00;
  localparam int unsigned clk_period_ns = 50;
  localparam int unsigned phase_two_half_ns = 100;
  localparam int unsigned phase_two_half_cycles =
    (phase_two_half_ns + clk_period_ns - 1) / clk_period_ns;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {pfm_cap_off, pfm_cap_fall, pfm_cap_rise, pfm_cap_both}
    pfm_cap_mode_type;
  typedef struct packed {
    logic emulation;
    logic abort_enable;
    logic nmi_enable;
  } pfm_bus_ctrl_type;
  typedef struct packed {
    logic irq;
    logic nmi;
    logic abort;
  } pfm_cpu_req_type;
endpackage : pfm_pkg

// *** hdl/pfm_edge_det.sv ***
// pfm_edge_det: registered edge detector for a pin sampled on the system clock
// assumes: input synchronous to sys_clk_in
`timescale 1ns/1ps
`default_nettype none
module pfm_edge_det (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic pin_in,
  output logic fall_out,
  output logic rise_out
);
  logic prev;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      // track the pin through reset so release never shows a false edge
      prev <= pin_in;
    end else begin
      prev <= pin_in;
    end
  end

  assign fall_out = prev & ~pin_in;
  assign rise_out = ~prev & pin_in;
endmodule : pfm_edge_det
`default_nettype wire

// *** hdl/pfm_phase_gen.sv ***
// pfm_phase_gen: divider giving the phase-two clock level and its rising pulse
// assumes: single system clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module pfm_phase_gen #(
  parameter int unsigned HALF_CYCLES = pfm_pkg::phase_two_half_cycles
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  output logic phase_two_clock_out,
  output logic phase_rise_out
);
  logic [7:0] count;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      count <= 8'h00;
      phase_two_clock_out <= 1'b0;
      phase_rise_out <= 1'b0;
    end else if (count == 8'(HALF_CYCLES - 1)) begin
      count <= 8'h00;
      phase_two_clock_out <= ~phase_two_clock_out;
      phase_rise_out <= ~phase_two_clock_out;
    end else begin
      count <= count + 8'h01;
      phase_rise_out <= 1'b0;
    end
  end
endmodule : pfm_phase_gen
`default_nettype wire

// *** verification/pfm_far_side.sv ***
// pfm_far_side: far side of the pins, timer pulse source and host irq input
// assumes: bench clock; changes just after rising edges
`timescale 1ns/1ps
`default_nettype none
module pfm_far_side (
  input wire logic sys_clk_in,
  input wire logic pulse_en_in,
  input wire logic host_irq_in,
  output logic tin_pin_out,
  output logic host_irq_seen_out
);
  logic [3:0] cnt = 4'h0;
  // ----------------------------------------
  // pulse train and host irq sampling
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    cnt <= (cnt == 4'h9 || !pulse_en_in) ? 4'h0 : cnt + 4'h1;
    host_irq_seen_out <= host_irq_in;
  end
  // five low, five high: below half the phase-two rate
  assign tin_pin_out = !pulse_en_in || (cnt > 4'h4);
endmodule : pfm_far_side
`default_nettype wire

// *** verification/pfm_pin_function_interrupt_mux_tb_top.sv ***
// pfm_pin_function_interrupt_mux_tb_top: random and corner checks of the pin mux
// assumes: design outputs registered one cycle after the inputs
`timescale 1ns/1ps
`default_nettype none
module pfm_pin_function_interrupt_mux_tb_top;
  typedef struct packed {
    logic rstn, lvl, en7, dis, clr, nmi, pen, t4, tmo, ebus, ewr, emu, pol, sel, wen, hirq;
    logic [3:0] rx, tx, txd;
    logic [7:0] csn, cse, p7, pin, pd, pdir;
    logic [2:0] rs;
  } pfm_tb_drive_type;
  pfm_tb_drive_type d, p;
  logic clk = 1'b0;
  logic quiet, rx0, t4, pen, nmi_en, ab_en, ef7, ew, cpin, clr3, timer4_count_in, hseen, hprev;
  logic [1:0] csel;
  logic [15:0] t7, el, lat;
  logic [7:0] cs_o, p6o, p6e;
  logic [3:0] rxd;
  logic [2:0] hreg;
  logic f7, lrq, nrq, arq, t4c, t4w, ph2, ba, dod, hacc, hwr, hirq_o, f3;
  int nf, tf, np, ap, tp, ph, cyc, mismatches, check_count;
  // ----------------------------------------
  // clock, design and far side
  // ----------------------------------------
  always #25 clk = ~clk;
  pfm_pin_mux i_pfm_pin_mux (
    .sys_clk_in(clk), .resetn_in(d.rstn),
    .chip_select_n_in(d.csn), .chip_select_enable_reg_in(d.cse), .port7_data_in(d.p7),
    .chip_select_out_n(cs_o), .level_irq_in_n(d.lvl), .edge_enable_bit_seven_in(d.en7),
    .cpu_irq_disable_in(d.dis), .edge_flag_clear_in(d.clr), .edge_flag_bit_seven_out(f7),
    .level_irq_req_out(lrq), .nonmaskable_irq_in_n(d.nmi),
    .bus_ctrl_in({d.emu, ab_en, nmi_en}), .nmi_req_out(nrq), .abort_req_out(arq),
    .serial_rx_enable_in(d.rx), .serial_tx_enable_in(d.tx), .serial_txd_in(d.txd),
    .port6_pin_in({d.pin[7:1], timer4_count_in}), .port6_data_in(d.pd), .port6_dir_in(d.pdir),
    .serial_rxd_out(rxd), .port6_pin_out(p6o), .port6_pin_oe_out(p6e),
    .timer4_enable_in(d.t4), .timer4_timeout_in(d.tmo), .timer4_count_out(t4c),
    .timer4_wave_out(t4w), .cpu_external_bus_in(d.ebus), .cpu_external_write_in(d.ewr),
    .phase_two_clock_out(ph2), .bus_avail_out(ba), .data_out_disable_n(dod),
    .host_port_select_polarity_in(d.pol), .host_port_select_pin_in(d.sel),
    .host_port_write_en_n(d.wen), .host_port_reg_select_in(d.rs),
    .host_irq_event_in(d.hirq), .host_port_access_out(hacc), .host_port_write_out(hwr),
    .host_port_reg_out(hreg), .host_port_irq_out(hirq_o), .capture_pin_in(cpin),
    .capture_edge_sel_lo(csel[0]), .capture_edge_sel_hi(csel[1]), .timer7_count_in(t7),
    .edge_flag_three_clear_in(clr3), .timer7_latch_out(lat), .edge_flag_bit_three_out(f3)
  );
  pfm_far_side i_pfm_far_side (
    .sys_clk_in(clk), .pulse_en_in(d.pen), .host_irq_in(hirq_o),
    .tin_pin_out(timer4_count_in), .host_irq_seen_out(hseen)
  );
  // ----------------------------------------
  // expectations and reporting
  // ----------------------------------------
  function automatic logic [15:0] exp_pins(input pfm_tb_drive_type v);
    logic [15:0] r;
    for (int u = 0; u < 4; u++) begin
      r[2*u] = v.pd[2*u];
      r[8+2*u] = v.pdir[2*u] & !v.rx[u];
      r[2*u+1] = v.tx[u] ? v.txd[u] : v.pd[2*u+1];
      r[9+2*u] = v.tx[u] | v.pdir[2*u+1];
    end
    if (v.t4 && !v.tx[0]) begin
      r[9] = 1'b1;
    end
    return r;
  endfunction : exp_pins
  function automatic logic [3:0] exp_rxd(input pfm_tb_drive_type v);
    logic [3:0] r;
    for (int u = 0; u < 4; u++) begin
      r[u] = v.rx[u] ? v.pin[2*u] : 1'b1;
    end
    return r;
  endfunction : exp_rxd
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ----------------------------------------
  // one cycle: check, count, drive
  // ----------------------------------------
  task automatic step();
    logic [15:0] m;
    logic [31:0] r1;
    logic [31:0] r2;
    @(negedge clk);
    m = (d.t4 && !d.tx[0]) ? 16'hfffd : 16'hffff;
    if (!d.rstn) begin
      ef7 = 1'b0;
      ew = 1'b0;
      ph = 0;
      chk(40'({cs_o, rxd, p6o, p6e, ba, dod}), 40'({8'hff, 4'hf, 16'h0, 2'b11}));
      chk(40'({f7, lrq, nrq, arq, f3, lat, ph2, t4c, t4w, hacc, hwr, hreg, hirq_o}), 40'h0);
    end else begin
      if (m[1] == 1'b0) begin
        chk(40'(p6o[1]), 40'(ew));
      end
      ef7 = !d.lvl | (ef7 & !d.clr);
      ew = ew ^ d.tmo;
      chk(40'(ph2), 40'(ph[1]));
      ph++;
      chk(40'(hseen), 40'(hprev));
      chk(40'(cs_o), 40'((d.cse & d.csn) | (~d.cse & d.p7)));
      chk(40'({f7, lrq}), 40'({ef7, !d.lvl & d.en7 & !d.dis}));
      chk(40'(rxd), 40'(exp_rxd(d)));
      chk(40'({p6e, p6o} & m), 40'(exp_pins(d) & m));
      chk(40'(t4w), 40'(ew));
      chk(40'({ba, dod}), 40'({ph2 ? (!d.emu | !d.ewr) : !d.ebus, !(ph2 & d.ewr)}));
      chk(40'({hacc, hwr, hreg, hirq_o}), 40'({d.pol ? d.sel : !d.sel, !d.wen, d.rs, d.hirq}));
    end
    nf += int'(p.nmi & !d.nmi);
    tf += int'(p.pin[0] & !d.pin[0]);
    np += int'(nrq);
    ap += int'(arq);
    tp += int'(t4c);
    hprev = hirq_o;
    p = d;
    r1 = $urandom;
    r2 = $urandom;
    {d.csn, d.cse, d.p7, d.pd} = {$urandom};
    {d.pin, d.pdir, d.rx, d.tx, d.txd, d.rs, d.lvl} = {r1[31:13], rx0, r1[11:0]};
    {d.en7, d.dis, d.tmo, d.ebus, d.ewr, d.emu, d.pol, d.sel, d.wen, d.hirq, d.nmi} =
      {r2[10:1], r2[0] | quiet};
    d.clr = ($urandom % 8) == 0;
    d.t4 = t4;
    d.pen = pen;
    #1 d.pin[0] = timer4_count_in;
  endtask : step
  // shared pin and timer input: pulses counted against falls
  task automatic seg(input logic [2:0] k);
    {t4, ab_en, nmi_en} = k;
    rx0 = k[1] & k[2];
    quiet = 1'b1;
    pen = 1'b0;
    repeat (4) step();
    {nf, tf, np, ap, tp} = '0;
    quiet = 1'b0;
    pen = 1'b1;
    repeat (60) step();
    quiet = 1'b1;
    pen = 1'b0;
    repeat (4) step();
    chk(40'(np), nmi_en ? 40'(nf) : 40'h0);
    chk(40'(ap), ab_en ? 40'(nf) : 40'h0);
    chk(40'(tp), (t4 && !rx0) ? 40'(tf) : 40'h0);
  endtask : seg
  // capture on rise then on fall for one edge selection
  task automatic cap(input logic [1:0] mode);
    cpin = 1'b0;
    csel = mode;
    repeat (3) step();
    clr3 = 1'b1;
    step();
    clr3 = 1'b0;
    t7 = 16'($urandom);
    repeat (2) step();
    cpin = 1'b1;
    repeat (3) step();
    chk(40'(f3), 40'(mode[1]));
    el = mode[1] ? t7 : el;
    clr3 = 1'b1;
    step();
    clr3 = 1'b0;
    step();
    cpin = 1'b0;
    repeat (3) step();
    chk(40'(f3), 40'(mode[0]));
    el = mode[0] ? t7 : el;
    chk(40'(lat), 40'(el));
  endtask : cap
  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    void'($urandom(5526));
    d = '0;
    d.nmi = 1'b1;
    p = d;
    {quiet, rx0, t4, pen, nmi_en, ab_en, ef7, ew, cpin, clr3} = 10'h200;
    csel = 2'h0;
    t7 = 16'h0;
    el = 16'h0;
    repeat (8) step();
    d.rstn = 1'b1;
    repeat (300) step();
    for (int k = 0; k < 8; k++) begin
      seg(3'(k));
    end
    // mid-run reset: outputs return to their reset values and restart cleanly
    d.rstn = 1'b0;
    repeat (3) step();
    d.rstn = 1'b1;
    for (int k = 0; k < 4; k++) begin
      cap(2'(k));
    end
    summarize();
  end
endmodule : pfm_pin_function_interrupt_mux_tb_top
`default_nettype wire
